// *** design/irq_ext_defs.svh ***
// Purpose: named constants of the extended interrupt enable/priority block
// Assumes: 8-bit special function register space
// Notes: offsets are byte addresses in that space
`ifndef IRQ_EXT_DEFS_SVH
`define IRQ_EXT_DEFS_SVH

`define ADDR_ENABLE_ONE 8'he6
`define ADDR_ENABLE_TWO 8'he7
`define ADDR_PRIORITY_ONE 8'hf6
`define ADDR_PRIORITY_TWO 8'hf7
`define ADDR_EXT_CONFIG 8'he4
`define ADDR_TIMER_CONTROL 8'h88
`define PAGE_EXT_CONFIG 8'h00

`define RESET_REG 8'h00
`define RESET_EXT_CONFIG 8'h01
`define RESET_TIMER_CONTROL_REG_LOW 4'h0
// pins idle high under their pull-ups
`define RESET_PINS 9'h1ff
`define RESET_REQ 14'h0000

`define MASK_ONE 8'hfd
`define MASK_TWO 8'h3b
`define ZERO_HIGH_NIBBLE 4'h0

`endif

// *** design/irq_ext_pkg.sv ***
// Purpose: types of the extended interrupt enable/priority block
// Assumes: field order follows the register bit layout, msb first
// Notes: none
package irq_ext_pkg;

  // bit 7 down to bit 0 of enable/priority register one
  typedef struct packed {
    logic timer3;
    logic comparator1;
    logic comparator0;
    logic counter_array;
    logic conversion_done;
    logic window_compare;
    logic reserved1;
    logic smbus_a;
  } group_one_t;

  // bit 7 down to bit 0 of enable/priority register two
  typedef struct packed {
    logic [1:0] unused;
    logic timer5;
    logic timer4;
    logic smbus_b;
    logic reserved2;
    logic uart_b;
    logic level_input;
  } group_two_t;

  typedef struct packed {
    logic ext_b_polarity;
    logic [2:0] ext_b_pin_select;
    logic ext_a_polarity;
    logic [2:0] ext_a_pin_select;
  } ext_config_t;

  // bits 3 down to 0 of the timer control register
  typedef struct packed {
    logic ext_b_pending;
    logic ext_b_edge_mode;
    logic ext_a_pending;
    logic ext_a_edge_mode;
  } timer_control_reg_low_t;

  typedef struct packed {
    logic timer3_low_overflow;
    logic timer3_high_overflow;
    logic comparator1_rise_flag;
    logic comparator1_fall_flag;
    logic comparator0_rise_flag;
    logic comparator0_fall_flag;
    logic counter_array_flag;
    logic conversion_done_flag;
    logic window_compare_flag;
    logic smbus_a_flag;
    logic timer4_low_overflow;
    logic timer4_high_overflow;
    logic timer5_low_overflow;
    logic timer5_high_overflow;
    logic smbus_b_flag;
    logic uart_b_flag;
  } source_flags_t;

  typedef struct packed {
    group_one_t enable_one;
    group_two_t enable_two;
    group_one_t priority_one;
    group_two_t priority_two;
    ext_config_t ext_config;
    timer_control_reg_low_t timer_control_reg_low;
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic [8:0] pins;
    logic ext_a_active_d;
    logic ext_b_active_d;
    logic [7:0] read_data;
    logic [13:0] request;
    logic [13:0] request_priority;
  } state_t;

endpackage

// *** design/ext_interrupt_enable_priority.sv ***
// Purpose: extended interrupt masking and priority, external input sensing
// Assumes: single system clock; core drives one-cycle register strobes
// Notes: read data appears one clock after the read strobe
//
// Summary of operation
// (RL1) enable register one, all pages, reset zero
// (RL2) timer 3 request from low or high overflow
// (RL3) comparator 1 rise or fall flag gated
// (RL4) comparator 0 rise or fall flag gated
// (RL5) conversion done and window compare gated
// (RL6) reserved bit 1 reads zero; software writes zero
// (RL7) priority one mirrors enable one, reset zero
// (RL8) enable register two bits, reset zero
// (RL9) bits 7:6 of group two read zero
// (RL10) timer 4 and 5 from either overflow
// (RL11) bit 0 gates level input request
// (RL12) priority two mirrors enable two
// (RL13) edge or level mode, selectable polarity
// (RL14) pins sampled without disturbing crossbar
// (RL15) pending flags at timer control bits 1, 3
// (RL16) edge pending cleared on vector entry
// (RL17) level pending follows active input
// (RL18) level source holds input until recognised
// (RL19) config bits 7 and 3 set polarity
// (RL20) pin select field n picks pin n
// (RL21) request needs flag, enable, global enable
`include "irq_ext_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ext_interrupt_enable_priority
  import irq_ext_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_pins,
  input wire logic level_input_c,
  input wire source_flags_t source_flags,
  input wire logic global_enable,
  input wire logic ext_a_vector_ack,
  input wire logic ext_b_vector_ack,
  output logic ext_a_pending,
  output logic ext_b_pending,
  output logic [13:0] irq_request,
  output logic [13:0] irq_priority
);

  state_t state;
  state_t next_state;

  // active level of the selected port 0 pin under the chosen polarity
  function automatic logic pin_active(input logic [7:0] pins, input logic [2:0] sel,
                                      input logic pol);
    pin_active = ~(pins[sel] ^ pol);
  endfunction

  // edge pending: a vector entry or software clear loses to a new edge
  function automatic logic edge_pending(input logic old_flag, input logic edge_seen,
                                        input logic ack, input logic wr_hit,
                                        input logic wr_value);
    logic kept;
    kept = wr_hit ? wr_value : (old_flag & ~ack);
    edge_pending = kept | edge_seen;
  endfunction

  logic hit_en1;
  logic hit_en2;
  logic hit_pr1;
  logic hit_pr2;
  logic hit_cfg;
  logic hit_timer_control_reg;
  logic act_a;
  logic act_b;
  logic edge_a;
  logic edge_b;
  group_one_t flags_one;
  group_two_t flags_two;

  always_comb begin
    next_state = state;
    hit_en1 = sfr_addr == `ADDR_ENABLE_ONE;
    hit_en2 = sfr_addr == `ADDR_ENABLE_TWO;
    hit_pr1 = sfr_addr == `ADDR_PRIORITY_ONE;
    hit_pr2 = sfr_addr == `ADDR_PRIORITY_TWO;
    hit_cfg = (sfr_addr == `ADDR_EXT_CONFIG) && (sfr_page == `PAGE_EXT_CONFIG);
    hit_timer_control_reg = sfr_addr == `ADDR_TIMER_CONTROL;

    // (RL1) all-page register writes
    // (RL6) reserved bits forced to zero
    if (sfr_wr && hit_en1) begin
      next_state.enable_one = group_one_t'(sfr_wdata & `MASK_ONE);
    end
    // (RL7) priority one writes
    if (sfr_wr && hit_pr1) begin
      next_state.priority_one = group_one_t'(sfr_wdata & `MASK_ONE);
    end
    // (RL8) enable two writes
    // (RL9) upper bits ignored
    if (sfr_wr && hit_en2) begin
      next_state.enable_two = group_two_t'(sfr_wdata & `MASK_TWO);
    end
    // (RL12) priority two writes
    if (sfr_wr && hit_pr2) begin
      next_state.priority_two = group_two_t'(sfr_wdata & `MASK_TWO);
    end
    // (RL19) polarity and pin select
    if (sfr_wr && hit_cfg) begin
      next_state.ext_config = ext_config_t'(sfr_wdata);
    end
    if (sfr_wr && hit_timer_control_reg) begin
      next_state.timer_control_reg_low.ext_a_edge_mode = sfr_wdata[0];
      next_state.timer_control_reg_low.ext_b_edge_mode = sfr_wdata[2];
    end

    // (RL14) read-only sampling, pins never driven
    next_state.sync1 = {level_input_c, port0_pins};
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    next_state.pins = (~(state.sync2 ^ state.sync3) & state.sync3)
                    | ((state.sync2 ^ state.sync3) & state.pins);

    // (RL20) pin select
    // (RL13) polarity applied
    act_a = pin_active(state.pins[7:0], state.ext_config.ext_a_pin_select,
                       state.ext_config.ext_a_polarity);
    act_b = pin_active(state.pins[7:0], state.ext_config.ext_b_pin_select,
                       state.ext_config.ext_b_polarity);
    edge_a = act_a & ~state.ext_a_active_d;
    edge_b = act_b & ~state.ext_b_active_d;
    next_state.ext_a_active_d = act_a;
    next_state.ext_b_active_d = act_b;

    // (RL15) pending flags in timer control
    // (RL16) edge pending cleared on vector
    // (RL17) level pending tracks input
    if (state.timer_control_reg_low.ext_a_edge_mode) begin
      next_state.timer_control_reg_low.ext_a_pending = edge_pending(state.timer_control_reg_low.ext_a_pending, edge_a,
                                                       ext_a_vector_ack, sfr_wr && hit_timer_control_reg,
                                                       sfr_wdata[1]);
    end else begin
      next_state.timer_control_reg_low.ext_a_pending = act_a;
    end
    if (state.timer_control_reg_low.ext_b_edge_mode) begin
      next_state.timer_control_reg_low.ext_b_pending = edge_pending(state.timer_control_reg_low.ext_b_pending, edge_b,
                                                       ext_b_vector_ack, sfr_wr && hit_timer_control_reg,
                                                       sfr_wdata[3]);
    end else begin
      next_state.timer_control_reg_low.ext_b_pending = act_b;
    end

    // (RL2) timer 3 either overflow
    // (RL3) comparator 1 either edge
    // (RL4) comparator 0 either edge
    // (RL5) converter flags
    flags_one.timer3 = source_flags.timer3_low_overflow | source_flags.timer3_high_overflow;
    flags_one.comparator1 = source_flags.comparator1_rise_flag
                          | source_flags.comparator1_fall_flag;
    flags_one.comparator0 = source_flags.comparator0_rise_flag
                          | source_flags.comparator0_fall_flag;
    flags_one.counter_array = source_flags.counter_array_flag;
    flags_one.conversion_done = source_flags.conversion_done_flag;
    flags_one.window_compare = source_flags.window_compare_flag;
    flags_one.reserved1 = 1'b0;
    flags_one.smbus_a = source_flags.smbus_a_flag;
    // (RL10) timers 4 and 5 either overflow
    // (RL11) level input request
    flags_two.unused = 2'b00;
    flags_two.timer5 = source_flags.timer5_low_overflow | source_flags.timer5_high_overflow;
    flags_two.timer4 = source_flags.timer4_low_overflow | source_flags.timer4_high_overflow;
    flags_two.smbus_b = source_flags.smbus_b_flag;
    flags_two.reserved2 = 1'b0;
    flags_two.uart_b = source_flags.uart_b_flag;
    // (RL18) level source relied on to hold input
    flags_two.level_input = ~state.pins[8];

    // (RL21) flag and enable and global enable
    next_state.request = {6'(flags_two & state.enable_two), 8'(flags_one & state.enable_one)}
                       & {14{global_enable}};
    next_state.request_priority = {6'(state.priority_two), 8'(state.priority_one)};

    if (sfr_rd) begin
      if (hit_en1) begin
        next_state.read_data = state.enable_one;
      end else if (hit_en2) begin
        next_state.read_data = state.enable_two;
      end else if (hit_pr1) begin
        next_state.read_data = state.priority_one;
      end else if (hit_pr2) begin
        next_state.read_data = state.priority_two;
      end else if (hit_cfg) begin
        next_state.read_data = state.ext_config;
      end else if (hit_timer_control_reg) begin
        next_state.read_data = {`ZERO_HIGH_NIBBLE, state.timer_control_reg_low};
      end else begin
        next_state.read_data = `RESET_REG;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.enable_one <= group_one_t'(`RESET_REG);
      state.enable_two <= group_two_t'(`RESET_REG);
      state.priority_one <= group_one_t'(`RESET_REG);
      state.priority_two <= group_two_t'(`RESET_REG);
      state.ext_config <= ext_config_t'(`RESET_EXT_CONFIG);
      state.timer_control_reg_low <= timer_control_reg_low_t'(`RESET_TIMER_CONTROL_REG_LOW);
      state.sync1 <= `RESET_PINS;
      state.sync2 <= `RESET_PINS;
      state.sync3 <= `RESET_PINS;
      state.pins <= `RESET_PINS;
      state.request <= `RESET_REQ;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata = state.read_data;
  assign ext_a_pending = state.timer_control_reg_low.ext_a_pending;
  assign ext_b_pending = state.timer_control_reg_low.ext_b_pending;
  assign irq_request = state.request;
  assign irq_priority = state.request_priority;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  reserved_one_zero_a: assert property ( // RL6
    !state.enable_one.reserved1 && !state.priority_one.reserved1)
    else $error("reserved bit of group one set");
  upper_two_zero_a: assert property ( // RL9
    state.enable_two.unused == 2'b00 && state.priority_two.unused == 2'b00
    && !state.enable_two.reserved2)
    else $error("unused bits of group two set");
  enable_write_a: assert property ( // RL1
    sfr_wr && hit_en1 |=> state.enable_one == ($past(sfr_wdata) & `MASK_ONE))
    else $error("enable one write lost");
  timer3_gate_a: assert property ( // RL2
    global_enable && state.enable_one.timer3 && source_flags.timer3_high_overflow
    |=> irq_request[7])
    else $error("timer 3 request missing");
  mask_blocks_a: assert property ( // RL3
    !state.enable_one.comparator1 |=> !irq_request[6])
    else $error("comparator 1 request not masked");
  comp0_gate_a: assert property ( // RL4
    global_enable && state.enable_one.comparator0 && source_flags.comparator0_fall_flag
    |=> irq_request[5])
    else $error("comparator 0 request missing");
  adc_gate_a: assert property ( // RL5
    global_enable && state.enable_one.conversion_done && source_flags.conversion_done_flag
    |=> irq_request[3])
    else $error("conversion done request missing");
  window_mask_a: assert property ( // RL5
    !state.enable_one.window_compare |=> !irq_request[2])
    else $error("window compare request not masked");
  priority_one_follow_a: assert property ( // RL7
    ##1 irq_priority[7:0] == $past(state.priority_one))
    else $error("priority one not presented");
  enable_two_write_a: assert property ( // RL8
    sfr_wr && hit_en2 |=> state.enable_two == ($past(sfr_wdata) & `MASK_TWO))
    else $error("enable two write lost");
  timer4_gate_a: assert property ( // RL10
    global_enable && state.enable_two.timer4 && source_flags.timer4_low_overflow
    |=> irq_request[12])
    else $error("timer 4 request missing");
  timer5_gate_a: assert property ( // RL10
    global_enable && state.enable_two.timer5 && source_flags.timer5_high_overflow
    |=> irq_request[13])
    else $error("timer 5 request missing");
  level_gate_a: assert property ( // RL11
    !state.enable_two.level_input |=> !irq_request[8])
    else $error("level input request not masked");
  global_off_a: assert property ( // RL21
    !global_enable |=> irq_request == 14'h0000)
    else $error("request without global enable");
  level_pending_a: assert property ( // RL17
    !state.timer_control_reg_low.ext_a_edge_mode && !$past(state.timer_control_reg_low.ext_a_edge_mode)
    |=> ext_a_pending == $past(act_a))
    else $error("level pending does not track input");
  pin_select_a: assert property ( // RL20
    !state.timer_control_reg_low.ext_b_edge_mode && !state.ext_config.ext_b_polarity
    && state.pins[state.ext_config.ext_b_pin_select] |=> !ext_b_pending)
    else $error("pending set on inactive input b");
  edge_set_wins_a: assert property ( // RL16
    state.timer_control_reg_low.ext_a_edge_mode && edge_a |=> ext_a_pending)
    else $error("edge lost against clear");
  ack_clears_a: assert property ( // RL16
    state.timer_control_reg_low.ext_b_edge_mode && ext_b_vector_ack && !edge_b && !(sfr_wr && hit_timer_control_reg)
    |=> !ext_b_pending)
    else $error("vector entry did not clear pending");
  config_write_a: assert property ( // RL19
    sfr_wr && hit_cfg |=> state.ext_config == $past(sfr_wdata))
    else $error("config write lost");
  pending_read_a: assert property ( // RL15
    sfr_rd && hit_timer_control_reg |=> sfr_rdata[1] == $past(ext_a_pending)
    && sfr_rdata[3] == $past(ext_b_pending))
    else $error("pending flags misplaced in timer control");
  priority_follow_a: assert property ( // RL12
    ##1 irq_priority[13:8] == $past(state.priority_two[5:0]))
    else $error("priority two not presented");

  edge_request_c: cover property (state.timer_control_reg_low.ext_a_edge_mode && edge_a ##1 ext_a_pending ##[1:5] ext_a_vector_ack);
  level_request_c: cover property (!state.timer_control_reg_low.ext_b_edge_mode ##1 ext_b_pending [*3] ##1 !ext_b_pending);
  high_priority_c: cover property (irq_request[13] && irq_priority[13]);
  config_read_c: cover property (sfr_rd && hit_cfg);
  timer4_request_c: cover property (irq_request[12]);

endmodule

`default_nettype wire

// *** bench/level_source.sv ***
// Purpose: far-side model of a level-sensed interrupt source
// Assumes: pin is active low and pulled high when released
// Notes: fire asserts the request, ack releases it
`timescale 1ns/1ps
`default_nettype none

module level_source (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fire,
  input wire logic ack,
  output logic pin_n
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_n <= 1'b1;
    end else if (fire) begin
      pin_n <= 1'b0;
    end else if (ack) begin
      pin_n <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the extended interrupt block
// Assumes: strobes, flags and pins change at the falling edge
// Notes: software writes of 8'hfb set unused bits 7:6 of enable two and priority two; the block masks them to zero
`timescale 1ns/1ps
`default_nettype none

module testbench
  import irq_ext_pkg::*;
;
  logic clk_sys, rst, sfr_wr, sfr_rd, global_enable;
  logic ack_a, ack_b, fire, rel, level_c, pend_a, pend_b;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, port0_pins;
  logic [13:0] irq_request, irq_priority;
  source_flags_t flags;
  int n_mismatch = 0;
  int num_checks = 0;

  ext_interrupt_enable_priority i_dut (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .port0_pins(port0_pins), .level_input_c(level_c), .source_flags(flags),
    .global_enable(global_enable), .ext_a_vector_ack(ack_a),
    .ext_b_vector_ack(ack_b), .ext_a_pending(pend_a), .ext_b_pending(pend_b),
    .irq_request(irq_request), .irq_priority(irq_priority));

  level_source i_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .ack(rel),
    .pin_n(level_c));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [13:0] seen, logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    @(negedge clk_sys);
    chk("sfr_rdata", 14'(sfr_rdata), 14'(exp));
  endtask

  // request bit raised by one source flag position
  function automatic logic [13:0] bit_of(int i);
    case (i)
      15, 14: bit_of = 14'h0080;
      13, 12: bit_of = 14'h0040;
      11, 10: bit_of = 14'h0020;
      9: bit_of = 14'h0010;
      8: bit_of = 14'h0008;
      7: bit_of = 14'h0004;
      6: bit_of = 14'h0001;
      5, 4: bit_of = 14'h1000;
      3, 2: bit_of = 14'h2000;
      1: bit_of = 14'h0800;
      0: bit_of = 14'h0200;
      default: bit_of = 14'h0000;
    endcase
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd, global_enable, ack_a, ack_b, fire, rel} = '0;
    {sfr_addr, sfr_page, sfr_wdata} = '0;
    port0_pins = 8'h08;
    flags = '0;
    idle(10);
    rst = 1'b0;
    rd(8'he6, 8'h00);
    rd(8'he7, 8'h00);
    rd(8'hf6, 8'h00);
    rd(8'hf7, 8'h00);
    rd(8'he4, 8'h01);
    sfr_page = 8'h01;
    rd(8'he4, 8'h00);
    rd(8'h55, 8'h00);
    sfr_page = 8'h00;
    wr(8'he6, 8'hfd);
    rd(8'he6, 8'hfd);
    wr(8'he7, 8'hfb);
    rd(8'he7, 8'h3b);
    wr(8'hf6, 8'ha5);
    rd(8'hf6, 8'ha5);
    wr(8'hf7, 8'hfb);
    rd(8'hf7, 8'h3b);
    global_enable = 1'b1;
    for (int i = 0; i < 16; i++) begin
      flags = source_flags_t'(16'h0001 << i);
      idle(2);
      chk("irq_request", irq_request, bit_of(i));
      chk("irq_priority", irq_priority, 14'h3ba5);
    end
    flags = source_flags_t'(16'h4000);
    global_enable = 1'b0;
    idle(2);
    chk("irq_request", irq_request, 14'h0000);
    global_enable = 1'b1;
    wr(8'he6, 8'h00);
    idle(1);
    chk("irq_request", irq_request, 14'h0000);
    flags = '0;
    // input a on pin 2 active high, input b on pin 3 active low
    wr(8'he4, 8'h3a);
    wr(8'h88, 8'h05);
    idle(8);
    chk("ext_a_pending", 14'(pend_a), 14'h0000);
    port0_pins = 8'h0c;
    idle(8);
    chk("ext_a_pending", 14'(pend_a), 14'h0001);
    port0_pins = 8'h08;
    idle(8);
    rd(8'h88, 8'h07);
    pulse(ack_a);
    idle(1);
    chk("ext_a_pending", 14'(pend_a), 14'h0000);
    port0_pins = 8'h00;
    idle(8);
    rd(8'h88, 8'h0d);
    pulse(ack_b);
    idle(1);
    chk("ext_b_pending", 14'(pend_b), 14'h0000);
    wr(8'h88, 8'h00);
    port0_pins = 8'h04;
    idle(8);
    chk("ext_a_pending", 14'(pend_a), 14'h0001);
    chk("ext_b_pending", 14'(pend_b), 14'h0001);
    port0_pins = 8'h08;
    idle(8);
    chk("ext_a_pending", 14'(pend_a), 14'h0000);
    chk("ext_b_pending", 14'(pend_b), 14'h0000);
    wr(8'he7, 8'h01);
    pulse(fire);
    for (int k = 0; k < 20 && irq_request[8] !== 1'b1; k++) begin
      @(negedge clk_sys);
    end
    chk("irq_request", irq_request, 14'h0100);
    pulse(rel);
    idle(8);
    chk("irq_request", irq_request, 14'h0000);
    summarize();
  end
endmodule

`default_nettype wire
